// ### rtl/rfd_pkg.sv
// shared constants and types for the request flag decoder
package rfd_pkg;
  // flag bit n sits at index n-1, bit 1 first on the air
  localparam int FLAG_W = 8;
  localparam int SUBC_POS = 0;
  localparam int RATE_POS = 1;
  localparam int INV_POS = 2;
  localparam int EXT_POS = 3;
  localparam int SEL_POS = 4;
  localparam int ADDR_POS = 5;
  localparam int OPT_POS = 6;
  localparam int RSV_POS = 7;
  localparam int RESP_ERR_POS = 0;
  localparam logic [2:0] UID_LAST = 3'h7;
  localparam logic [7:0] CMD_SYSINFO = 8'h2b;
  // register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_UID_LO = 8'h08;
  localparam logic [7:0] REG_UID_HI = 8'h0c;
  localparam logic [7:0] REG_STATE = 8'h10;
  localparam int CTRL_EN_POS = 0;
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;
  localparam logic [63:0] UID_RST = 64'h0;
  // tag states
  localparam logic [1:0] TAG_READY = 2'h0;
  localparam logic [1:0] TAG_QUIET = 2'h1;
  localparam logic [1:0] TAG_SELECTED = 2'h2;
  localparam logic [1:0] TAG_STATE_RST = 2'h0;
  typedef enum logic [5:0] {
    RX_IDLE = 6'b000001,
    RX_FLAGS = 6'b000010,
    RX_CMD = 6'b000100,
    RX_FAM = 6'b001000,
    RX_UID = 6'b010000,
    RX_BODY = 6'b100000
  } rfd_rx_type;
  typedef enum logic [7:0] {
    TX_IDLE = 8'b00000001,
    TX_SOF = 8'b00000010,
    TX_FLAG = 8'b00000100,
    TX_CODE = 8'b00001000,
    TX_DATA = 8'b00010000,
    TX_CRCL = 8'b00100000,
    TX_CRCH = 8'b01000000,
    TX_EOF = 8'b10000000
  } rfd_tx_type;
endpackage

// ### rtl/rfd_flag_if.sv
// decoded request flag fields between frame parser and decoder
`timescale 1ns/100ps
interface rfd_flag_if;
  logic [7:0] flags;
  logic [1:0] tag_state;
  logic uid_ok;
  logic enable;
  logic two_sub;
  logic high_rate;
  logic inventory;
  logic ext;
  logic select_only;
  logic uid_present;
  logic family_present;
  logic single_slot;
  logic option;
  logic reserved_err;
  logic exec_ok;
  modport dec (
    input flags, tag_state, uid_ok, enable,
    output two_sub, high_rate, inventory, ext, select_only, uid_present,
    output family_present, single_slot, option, reserved_err, exec_ok
  );
  modport top (
    output flags, tag_state, uid_ok, enable,
    input two_sub, high_rate, inventory, ext, select_only, uid_present,
    input family_present, single_slot, option, reserved_err, exec_ok
  );
endinterface

// ### rtl/rfd_flag_dec.sv
// request flag byte decoder and execute decision
`timescale 1ns/100ps
module rfd_flag_dec (
  rfd_flag_if.dec fl // flag byte in, fields and decision out
);
  always_comb
  begin
    fl.two_sub = fl.flags[rfd_pkg::SUBC_POS];
    fl.high_rate = fl.flags[rfd_pkg::RATE_POS];
    fl.inventory = fl.flags[rfd_pkg::INV_POS];
    fl.ext = fl.flags[rfd_pkg::EXT_POS];
    fl.option = fl.flags[rfd_pkg::OPT_POS];
    fl.reserved_err = fl.flags[rfd_pkg::RSV_POS];
    // meaning of bits 5 and 6 switches on the inventory bit
    fl.select_only = !fl.inventory && fl.flags[rfd_pkg::SEL_POS];
    fl.uid_present = !fl.inventory && fl.flags[rfd_pkg::ADDR_POS];
    fl.family_present = fl.inventory && fl.flags[rfd_pkg::SEL_POS];
    fl.single_slot = fl.inventory && fl.flags[rfd_pkg::ADDR_POS];
    if (!fl.enable)
    begin
      fl.exec_ok = 1'b0;
    end
    else if (fl.inventory)
    begin
      // quiet tags skip inventories with the address bit set
      fl.exec_ok = !(fl.tag_state == rfd_pkg::TAG_QUIET &&
        fl.flags[rfd_pkg::ADDR_POS]);
    end
    else if (fl.select_only)
    begin
      fl.exec_ok = fl.tag_state == rfd_pkg::TAG_SELECTED;
    end
    else if (fl.uid_present)
    begin
      fl.exec_ok = fl.uid_ok;
    end
    else
    begin
      fl.exec_ok = 1'b1;
    end
  end
endmodule

// ### rtl/rfd_resp_tx.sv
// response frame builder: sof, flag byte, error code, data, crc, eof
`timescale 1ns/100ps
module rfd_resp_tx (
  input wire logic sys_clk_i, // system clock
  input wire logic reset_n_i, // sync reset, active low
  input wire logic start_i, // start a response
  input wire logic err_i, // response carries an error
  input wire logic [7:0] code_i, // error code
  input wire logic pl_i, // response has data bytes
  input wire logic [15:0] crc_i, // crc, low byte sent first
  input wire logic pl_valid_i, // data byte offered
  input wire logic [7:0] pl_byte_i, // data byte
  input wire logic pl_last_i, // last data byte
  output logic pl_ready_o, // data byte taken when valid
  output logic tx_sof_o, // start of frame pulse
  output logic tx_valid_o, // byte pulse
  output logic [7:0] tx_byte_o, // byte to send
  output logic tx_eof_o, // end of frame pulse
  output logic busy_o // frame in progress
);
  function automatic logic [7:0] resp_flags(input logic err);
    resp_flags = 8'h00; // reserved and extension bits stay clear
    resp_flags[rfd_pkg::RESP_ERR_POS] = err;
  endfunction

  rfd_pkg::rfd_tx_type fsm_ff, nxt_fsm;
  logic err_ff, nxt_err, pl_ff, nxt_pl;
  logic [7:0] code_ff, nxt_code;
  logic [15:0] crc_ff, nxt_crc;
  logic nxt_sof, nxt_valid, nxt_eof;
  logic [7:0] nxt_byte;

  always_comb
  begin
    nxt_fsm = fsm_ff;
    nxt_err = err_ff;
    nxt_pl = pl_ff;
    nxt_code = code_ff;
    nxt_crc = crc_ff;
    nxt_sof = 1'b0;
    nxt_valid = 1'b0;
    nxt_eof = 1'b0;
    nxt_byte = 8'h00;
    case (fsm_ff)
      rfd_pkg::TX_IDLE:
        if (start_i)
        begin
          nxt_err = err_i;
          nxt_pl = pl_i;
          nxt_code = code_i;
          nxt_crc = crc_i;
          nxt_fsm = rfd_pkg::TX_SOF;
        end
      rfd_pkg::TX_SOF:
      begin
        nxt_sof = 1'b1;
        nxt_fsm = rfd_pkg::TX_FLAG;
      end
      rfd_pkg::TX_FLAG:
      begin
        nxt_valid = 1'b1;
        nxt_byte = resp_flags(err_ff);
        nxt_fsm = err_ff ? rfd_pkg::TX_CODE :
          (pl_ff ? rfd_pkg::TX_DATA : rfd_pkg::TX_CRCL);
      end
      rfd_pkg::TX_CODE:
      begin
        nxt_valid = 1'b1;
        nxt_byte = code_ff;
        nxt_fsm = pl_ff ? rfd_pkg::TX_DATA : rfd_pkg::TX_CRCL;
      end
      rfd_pkg::TX_DATA:
        if (pl_valid_i)
        begin
          nxt_valid = 1'b1;
          nxt_byte = pl_byte_i;
          if (pl_last_i)
          begin
            nxt_fsm = rfd_pkg::TX_CRCL;
          end
        end
      rfd_pkg::TX_CRCL:
      begin
        nxt_valid = 1'b1;
        nxt_byte = crc_ff[7:0];
        nxt_fsm = rfd_pkg::TX_CRCH;
      end
      rfd_pkg::TX_CRCH:
      begin
        nxt_valid = 1'b1;
        nxt_byte = crc_ff[15:8];
        nxt_fsm = rfd_pkg::TX_EOF;
      end
      rfd_pkg::TX_EOF:
      begin
        nxt_eof = 1'b1;
        nxt_fsm = rfd_pkg::TX_IDLE;
      end
      default: nxt_fsm = rfd_pkg::TX_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!reset_n_i)
    begin
      fsm_ff <= rfd_pkg::TX_IDLE;
      err_ff <= 1'b0;
      pl_ff <= 1'b0;
      code_ff <= 8'h00;
      crc_ff <= 16'h0000;
      tx_sof_o <= 1'b0;
      tx_valid_o <= 1'b0;
      tx_byte_o <= 8'h00;
      tx_eof_o <= 1'b0;
      pl_ready_o <= 1'b0;
      busy_o <= 1'b0;
    end
    else
    begin
      fsm_ff <= nxt_fsm;
      err_ff <= nxt_err;
      pl_ff <= nxt_pl;
      code_ff <= nxt_code;
      crc_ff <= nxt_crc;
      tx_sof_o <= nxt_sof;
      tx_valid_o <= nxt_valid;
      tx_byte_o <= nxt_byte;
      tx_eof_o <= nxt_eof;
      pl_ready_o <= nxt_fsm == rfd_pkg::TX_DATA;
      busy_o <= nxt_fsm != rfd_pkg::TX_IDLE;
    end
  end

  sequence start_s;
    start_i && fsm_ff == rfd_pkg::TX_IDLE;
  endsequence
  sequence head_s;
    start_s ##2 tx_sof_o;
  endsequence

  resp_flag_byte_a: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i)
    head_s |=> tx_valid_o && tx_byte_o == resp_flags($past(err_i, 3)))
    else $error("response flag byte wrong after start");
  resp_err_code_a: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i)
    head_s ##1 (tx_valid_o && tx_byte_o[rfd_pkg::RESP_ERR_POS])
    |=> tx_valid_o && tx_byte_o == $past(code_i, 4))
    else $error("error code byte missing after error flag");
  resp_no_pl_a: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i)
    (start_s and !err_i && !pl_i)
    |-> ##3 tx_valid_o ##1 tx_valid_o ##1 tx_valid_o ##1 tx_eof_o)
    else $error("short response not flag, crc, crc, eof");
endmodule

// ### rtl/rfd_top.sv
// request flag decoder top: frame parser, registers, response builder
// Notes on behaviour
// - no UID flag: execute and answer
// - select-only flag: answer only when Selected
// - inventory bit switches meaning of bits 5-6
// - bit 1 picks one or two subcarriers
// - bit 2 picks reply data rate
// - bit 4 marks extended protocol format
// - system info layout follows extension bit
// - bit 5 restricts execution to Selected
// - bit 6 means UID present, must match (UID not read or compared when bit 5 set)
// - bit 7 option, bit 8 reserved zero (a set bit 8 is only reported in status, request still executes)
// - inventory: bit 5 family byte, bit 6 slots
// - response: sof, flags, data, crc, eof
// - error flag set adds error code
// - extension and reserved response bits zero
// - Ready answers when select flag clear
// - Quiet skips addressed inventory requests
// - addressed, select flag clear: compare UID, silent on mismatch
`timescale 1ns/100ps
module rfd_top (
  input wire logic sys_clk_i, // 125 MHz system clock
  input wire logic reset_n_i, // sync reset, active low (field loss)
  input wire logic [7:0] reg_addr_i, // register byte address
  input wire logic [31:0] reg_wdata_i, // register write data
  input wire logic reg_wr_i, // register write strobe
  input wire logic reg_rd_i, // register read strobe
  output logic [31:0] reg_rdata_o, // read data, cycle after strobe
  input wire logic rx_sof_i, // request start of frame
  input wire logic rx_valid_i, // request byte strobe
  input wire logic [7:0] rx_byte_i, // request byte
  input wire logic rx_eof_i, // request end of frame
  input wire logic rx_crc_ok_i, // crc good, with end of frame
  output logic exec_o, // pulse: execute the request
  output logic [7:0] cmd_o, // command code of executed request
  output logic inventory_o, // request is an inventory
  output logic ext_o, // extended protocol format
  output logic option_o, // command option active
  output logic rich_info_o, // system info with richer layout
  output logic family_vld_o, // family byte was present
  output logic [7:0] family_o, // family byte
  output logic single_slot_o, // one slot instead of sixteen
  output logic tx_two_sub_o, // reply with two subcarriers
  output logic tx_high_rate_o, // reply at high data rate
  input wire logic resp_start_i, // start a response frame
  input wire logic resp_err_i, // response carries an error
  input wire logic [7:0] resp_code_i, // error code
  input wire logic resp_pl_i, // response has data bytes
  input wire logic [15:0] resp_crc_i, // response crc
  input wire logic pl_valid_i, // response data byte offered
  input wire logic [7:0] pl_byte_i, // response data byte
  input wire logic pl_last_i, // last response data byte
  output logic pl_ready_o, // response data byte taken
  output logic tx_sof_o, // response start of frame
  output logic tx_valid_o, // response byte strobe
  output logic [7:0] tx_byte_o, // response byte
  output logic tx_eof_o // response end of frame
);
  rfd_flag_if fl ();
  rfd_flag_dec u_dec (
    .fl(fl)
  );

  logic tx_busy;
  rfd_resp_tx u_tx (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .start_i(resp_start_i),
    .err_i(resp_err_i),
    .code_i(resp_code_i),
    .pl_i(resp_pl_i),
    .crc_i(resp_crc_i),
    .pl_valid_i(pl_valid_i),
    .pl_byte_i(pl_byte_i),
    .pl_last_i(pl_last_i),
    .pl_ready_o(pl_ready_o),
    .tx_sof_o(tx_sof_o),
    .tx_valid_o(tx_valid_o),
    .tx_byte_o(tx_byte_o),
    .tx_eof_o(tx_eof_o),
    .busy_o(tx_busy)
  );

  // registers
  logic [31:0] ctrl_ff, nxt_ctrl;
  logic [63:0] uid_ff, nxt_uid;
  logic [1:0] tag_state_ff, nxt_tag_state;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [31:0] status;

  // request parser state
  rfd_pkg::rfd_rx_type rx_fsm_ff, nxt_rx_fsm;
  logic [7:0] flags_ff, nxt_flags;
  logic [7:0] rcmd_ff, nxt_rcmd;
  logic [7:0] rfam_ff, nxt_rfam;
  logic [2:0] uid_idx_ff, nxt_uid_idx;
  logic uid_ok_ff, nxt_uid_ok;
  logic last_exec_ff, nxt_last_exec;
  logic accept;

  // latched request outputs
  logic exec_ff, nxt_exec;
  logic [7:0] cmd_ff, nxt_cmd;
  logic inv_ff, nxt_inv, ext_ff, nxt_ext, opt_ff, nxt_opt;
  logic rich_ff, nxt_rich, famv_ff, nxt_famv;
  logic [7:0] fam_ff, nxt_fam;
  logic slot_ff, nxt_slot, sub_ff, nxt_sub, rate_ff, nxt_rate;

  function automatic logic [7:0] uid_byte(input logic [63:0] uid,
    input logic [2:0] idx);
    uid_byte = uid[{idx, 3'h0} +: 8]; // identifier goes lsbyte first
  endfunction

  always_comb
  begin
    fl.flags = flags_ff;
    fl.tag_state = tag_state_ff;
    fl.uid_ok = uid_ok_ff;
    fl.enable = ctrl_ff[rfd_pkg::CTRL_EN_POS];
  end

  assign status = {12'h000, tx_busy, rx_fsm_ff != rfd_pkg::RX_IDLE,
    fl.reserved_err, last_exec_ff, rcmd_ff, flags_ff};

  // register bus
  always_comb
  begin
    nxt_ctrl = ctrl_ff;
    nxt_uid = uid_ff;
    nxt_tag_state = tag_state_ff;
    nxt_rdata = 32'h0000_0000;
    if (reg_wr_i)
    begin
      case (reg_addr_i)
        rfd_pkg::REG_CTRL: nxt_ctrl = reg_wdata_i;
        rfd_pkg::REG_UID_LO: nxt_uid[31:0] = reg_wdata_i;
        rfd_pkg::REG_UID_HI: nxt_uid[63:32] = reg_wdata_i;
        rfd_pkg::REG_STATE: nxt_tag_state = reg_wdata_i[1:0];
        default: nxt_ctrl = ctrl_ff;
      endcase
    end
    if (reg_rd_i)
    begin
      case (reg_addr_i)
        rfd_pkg::REG_CTRL: nxt_rdata = ctrl_ff;
        rfd_pkg::REG_STATUS: nxt_rdata = status;
        rfd_pkg::REG_UID_LO: nxt_rdata = uid_ff[31:0];
        rfd_pkg::REG_UID_HI: nxt_rdata = uid_ff[63:32];
        rfd_pkg::REG_STATE: nxt_rdata = {30'h0, tag_state_ff};
        default: nxt_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!reset_n_i)
    begin
      ctrl_ff <= rfd_pkg::CTRL_RST;
      uid_ff <= rfd_pkg::UID_RST;
      tag_state_ff <= rfd_pkg::TAG_STATE_RST;
      rdata_ff <= 32'h0000_0000;
    end
    else
    begin
      ctrl_ff <= nxt_ctrl;
      uid_ff <= nxt_uid;
      tag_state_ff <= nxt_tag_state;
      rdata_ff <= nxt_rdata;
    end
  end

  // request parser: flags, command, family or uid, then body
  assign accept = rx_eof_i && rx_crc_ok_i && rx_fsm_ff == rfd_pkg::RX_BODY
    && fl.exec_ok;

  always_comb
  begin
    nxt_rx_fsm = rx_fsm_ff;
    nxt_flags = flags_ff;
    nxt_rcmd = rcmd_ff;
    nxt_rfam = rfam_ff;
    nxt_uid_idx = uid_idx_ff;
    nxt_uid_ok = uid_ok_ff;
    if (rx_sof_i)
    begin
      nxt_rx_fsm = rfd_pkg::RX_FLAGS;
    end
    else if (rx_eof_i)
    begin
      // short or bad frames fall back silently
      nxt_rx_fsm = rfd_pkg::RX_IDLE;
    end
    else if (rx_valid_i)
    begin
      case (rx_fsm_ff)
        rfd_pkg::RX_FLAGS:
        begin
          nxt_flags = rx_byte_i;
          nxt_uid_idx = 3'h0;
          nxt_uid_ok = 1'b1;
          nxt_rfam = 8'h00;
          nxt_rx_fsm = rfd_pkg::RX_CMD;
        end
        rfd_pkg::RX_CMD:
        begin
          nxt_rcmd = rx_byte_i;
          if (fl.family_present)
          begin
            nxt_rx_fsm = rfd_pkg::RX_FAM;
          end
          else if (fl.uid_present && !fl.flags[rfd_pkg::SEL_POS])
          begin
            nxt_rx_fsm = rfd_pkg::RX_UID;
          end
          else
          begin
            nxt_rx_fsm = rfd_pkg::RX_BODY;
          end
        end
        rfd_pkg::RX_FAM:
        begin
          nxt_rfam = rx_byte_i;
          nxt_rx_fsm = rfd_pkg::RX_BODY;
        end
        rfd_pkg::RX_UID:
        begin
          nxt_uid_ok = uid_ok_ff &&
            rx_byte_i == uid_byte(uid_ff, uid_idx_ff);
          nxt_uid_idx = uid_idx_ff + 3'h1;
          if (uid_idx_ff == rfd_pkg::UID_LAST)
          begin
            nxt_rx_fsm = rfd_pkg::RX_BODY;
          end
        end
        rfd_pkg::RX_BODY: nxt_rx_fsm = rfd_pkg::RX_BODY;
        rfd_pkg::RX_IDLE: nxt_rx_fsm = rfd_pkg::RX_IDLE;
        default: nxt_rx_fsm = rfd_pkg::RX_IDLE;
      endcase
    end
  end

  // results, latched when a request is accepted
  always_comb
  begin
    nxt_exec = accept;
    nxt_last_exec = last_exec_ff;
    nxt_cmd = cmd_ff;
    nxt_inv = inv_ff;
    nxt_ext = ext_ff;
    nxt_opt = opt_ff;
    nxt_rich = rich_ff;
    nxt_famv = famv_ff;
    nxt_fam = fam_ff;
    nxt_slot = slot_ff;
    nxt_sub = sub_ff;
    nxt_rate = rate_ff;
    if (rx_eof_i)
    begin
      nxt_last_exec = accept;
    end
    if (accept)
    begin
      nxt_cmd = rcmd_ff;
      nxt_inv = fl.inventory;
      nxt_ext = fl.ext;
      nxt_opt = fl.option;
      nxt_rich = fl.ext && rcmd_ff == rfd_pkg::CMD_SYSINFO;
      nxt_famv = fl.family_present;
      nxt_fam = rfam_ff;
      nxt_slot = fl.single_slot;
      nxt_sub = fl.two_sub;
      nxt_rate = fl.high_rate;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!reset_n_i)
    begin
      rx_fsm_ff <= rfd_pkg::RX_IDLE;
      flags_ff <= 8'h00;
      rcmd_ff <= 8'h00;
      rfam_ff <= 8'h00;
      uid_idx_ff <= 3'h0;
      uid_ok_ff <= 1'b0;
      last_exec_ff <= 1'b0;
      exec_ff <= 1'b0;
      cmd_ff <= 8'h00;
      inv_ff <= 1'b0;
      ext_ff <= 1'b0;
      opt_ff <= 1'b0;
      rich_ff <= 1'b0;
      famv_ff <= 1'b0;
      fam_ff <= 8'h00;
      slot_ff <= 1'b0;
      sub_ff <= 1'b0;
      rate_ff <= 1'b0;
    end
    else
    begin
      rx_fsm_ff <= nxt_rx_fsm;
      flags_ff <= nxt_flags;
      rcmd_ff <= nxt_rcmd;
      rfam_ff <= nxt_rfam;
      uid_idx_ff <= nxt_uid_idx;
      uid_ok_ff <= nxt_uid_ok;
      last_exec_ff <= nxt_last_exec;
      exec_ff <= nxt_exec;
      cmd_ff <= nxt_cmd;
      inv_ff <= nxt_inv;
      ext_ff <= nxt_ext;
      opt_ff <= nxt_opt;
      rich_ff <= nxt_rich;
      famv_ff <= nxt_famv;
      fam_ff <= nxt_fam;
      slot_ff <= nxt_slot;
      sub_ff <= nxt_sub;
      rate_ff <= nxt_rate;
    end
  end

  assign reg_rdata_o = rdata_ff;
  assign exec_o = exec_ff;
  assign cmd_o = cmd_ff;
  assign inventory_o = inv_ff;
  assign ext_o = ext_ff;
  assign option_o = opt_ff;
  assign rich_info_o = rich_ff;
  assign family_vld_o = famv_ff;
  assign family_o = fam_ff;
  assign single_slot_o = slot_ff;
  assign tx_two_sub_o = sub_ff;
  assign tx_high_rate_o = rate_ff;

  sequence end_ok_s;
    rx_eof_i && rx_crc_ok_i && rx_fsm_ff == rfd_pkg::RX_BODY;
  endsequence

  exec_select_a: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i)
    end_ok_s and fl.select_only && tag_state_ff != rfd_pkg::TAG_SELECTED
    |=> !exec_o)
    else $error("select-only request executed outside Selected");
  exec_plain_a: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i)
    end_ok_s and !fl.inventory && !fl.flags[rfd_pkg::SEL_POS] &&
    !fl.flags[rfd_pkg::ADDR_POS] && fl.enable |=> exec_o)
    else $error("non-addressed request not executed");
  uid_match_a: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i)
    end_ok_s and fl.uid_present && !fl.flags[rfd_pkg::SEL_POS]
    |=> exec_o == ($past(uid_ok_ff) && $past(fl.enable)))
    else $error("addressed request decision ignores uid compare");
  quiet_inv_a: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i)
    end_ok_s and fl.inventory && tag_state_ff == rfd_pkg::TAG_QUIET &&
    fl.flags[rfd_pkg::ADDR_POS] |=> !exec_o)
    else $error("quiet tag answered addressed inventory");
  reply_mode_a: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i)
    exec_o |-> tx_two_sub_o == $past(flags_ff[rfd_pkg::SUBC_POS]) &&
    tx_high_rate_o == $past(flags_ff[rfd_pkg::RATE_POS]))
    else $error("reply modulation not taken from request flags");
  inv_fields_a: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i)
    exec_o && inventory_o |-> family_vld_o ==
    $past(flags_ff[rfd_pkg::SEL_POS]) &&
    single_slot_o == $past(flags_ff[rfd_pkg::ADDR_POS]))
    else $error("inventory fields decoded wrongly");
  rich_info_a: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i)
    exec_o && cmd_o == rfd_pkg::CMD_SYSINFO |-> rich_info_o == ext_o)
    else $error("system info layout does not follow extension");
  reg_read_a: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i)
    reg_rd_i && reg_addr_i == rfd_pkg::REG_STATE && !reg_wr_i
    |=> reg_rdata_o == {30'h0, $past(tag_state_ff)} ##1
    reg_rdata_o == 32'h0 || $past(reg_rd_i))
    else $error("state register read data wrong");
endmodule

// ### verif/rfd_reader.sv
// reader model that issues request frames to the tag
`timescale 1ns/100ps
module rfd_reader #(
  parameter logic [7:0] BLK_CMD = 8'h20 // block read code, always sent with extension bit set
) (
  input wire logic sys_clk_i, // system clock
  output logic rx_sof_o, // start of frame
  output logic rx_valid_o, // byte strobe
  output logic [7:0] rx_byte_o, // request byte
  output logic rx_eof_o, // end of frame
  output logic rx_crc_ok_o // crc good, with eof
);
  initial
  begin
    rx_sof_o = 1'b0;
    rx_valid_o = 1'b0;
    rx_byte_o = 8'h00;
    rx_eof_o = 1'b0;
    rx_crc_ok_o = 1'b0;
  end
  task automatic frame(input logic [7:0] b [0:11], input int n,
    input logic ok);
    logic [7:0] f;
    f = b[0];
    if (!f[2] && f[4])
      f[5] = 1'b0;
    if (b[1] === BLK_CMD)
      f[3] = 1'b1;
    @(posedge sys_clk_i);
    rx_sof_o <= 1'b1;
    for (int i = 0; i < n; i++)
    begin
      @(posedge sys_clk_i);
      rx_sof_o <= 1'b0;
      rx_valid_o <= 1'b1;
      rx_byte_o <= (i == 0) ? f : b[i];
    end
    @(posedge sys_clk_i);
    rx_valid_o <= 1'b0;
    rx_byte_o <= ~rx_byte_o;
    rx_eof_o <= 1'b1;
    rx_crc_ok_o <= ok;
    @(posedge sys_clk_i);
    rx_eof_o <= 1'b0;
    rx_crc_ok_o <= ~ok;
  endtask
endmodule

// ### verif/test_rf_request_flag_decoder.sv
// self-checking bench for the request flag decoder
`timescale 1ns/100ps
module test_rf_request_flag_decoder;
  logic sys_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [31:0] reg_rdata_o, rd;
  logic rx_sof_i, rx_valid_i, rx_eof_i, rx_crc_ok_i;
  logic [7:0] rx_byte_i, cmd_o, family_o, tx_byte_o;
  logic exec_o, inventory_o, ext_o, option_o, rich_info_o, family_vld_o;
  logic single_slot_o, tx_two_sub_o, tx_high_rate_o;
  logic tx_sof_o, tx_valid_o, tx_eof_o;
  logic resp_start_i = 1'b0;
  logic resp_err_i = 1'b0;
  logic [7:0] resp_code_i = 8'h00;
  logic [15:0] resp_crc_i = 16'h0;
  logic resp_pl_i = 1'b0;
  logic pl_valid_i = 1'b0;
  logic [7:0] pl_byte_i = 8'h00;
  logic pl_last_i = 1'b0;
  logic pl_ready_o;
  logic [7:0] fr [0:11];
  logic [7:0] txq [$];
  int bad_count = 0;
  int n_compared = 0;
  int n_exec = 0;
  int n_sof = 0;
  int cyc = 0;
  always #4 sys_clk_i = ~sys_clk_i;
  rfd_top i_dut (.sys_clk_i, .reset_n_i, .reg_addr_i, .reg_wdata_i,
    .reg_wr_i, .reg_rd_i, .reg_rdata_o, .rx_sof_i, .rx_valid_i,
    .rx_byte_i, .rx_eof_i, .rx_crc_ok_i, .exec_o, .cmd_o, .inventory_o,
    .ext_o, .option_o, .rich_info_o, .family_vld_o, .family_o,
    .single_slot_o, .tx_two_sub_o, .tx_high_rate_o, .resp_start_i,
    .resp_err_i, .resp_code_i, .resp_pl_i, .resp_crc_i,
    .pl_valid_i, .pl_byte_i, .pl_last_i,
    .pl_ready_o, .tx_sof_o, .tx_valid_o, .tx_byte_o, .tx_eof_o);
  rfd_reader i_rdr (.sys_clk_i(sys_clk_i), .rx_sof_o(rx_sof_i),
    .rx_valid_o(rx_valid_i), .rx_byte_o(rx_byte_i), .rx_eof_o(rx_eof_i),
    .rx_crc_ok_o(rx_crc_ok_i));
  task automatic stop_test();
    if (bad_count == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge sys_clk_i)
  begin
    cyc <= cyc + 1;
    if (exec_o === 1'b1)
      n_exec <= n_exec + 1;
    if (tx_sof_o === 1'b1)
      n_sof <= n_sof + 1;
    if (tx_valid_o === 1'b1)
      txq.push_back(tx_byte_o);
    if (cyc == 3000)
    begin
      bad_count++;
      stop_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic reg_rd(input logic [7:0] a);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    rd = reg_rdata_o;
  endtask
  task automatic req(input int n, input logic ok, input int exp);
    int e0;
    e0 = n_exec;
    i_rdr.frame(fr, n, ok);
    repeat (3) @(posedge sys_clk_i);
    chk(n_exec - e0, exp);
  endtask
  task automatic t_regs();
    reg_rd(rfd_pkg::REG_CTRL);
    chk(rd, 32'h1);
    reg_rd(rfd_pkg::REG_STATE);
    chk(rd, 32'h0);
    reg_rd(8'h20);
    chk(rd, 32'h0);
  endtask
  task automatic t_plain();
    fr[0] = 8'h02;
    fr[1] = 8'h33;
    req(2, 1'b1, 1);
    chk({cmd_o, tx_high_rate_o, tx_two_sub_o}, 10'h0ce);
    fr[0] = 8'h01;
    req(2, 1'b1, 1);
    chk({tx_high_rate_o, tx_two_sub_o}, 2'h1);
    req(2, 1'b0, 0);
    req(1, 1'b1, 0);
    reg_wr(rfd_pkg::REG_CTRL, 32'h0);
    req(2, 1'b1, 0);
    reg_wr(rfd_pkg::REG_CTRL, 32'h1);
  endtask
  task automatic t_select();
    fr[0] = 8'h30;
    req(2, 1'b1, 0);
    reg_wr(rfd_pkg::REG_STATE, 32'h2);
    req(2, 1'b1, 1);
    reg_wr(rfd_pkg::REG_STATE, 32'h0);
  endtask
  task automatic t_addr();
    reg_wr(rfd_pkg::REG_UID_LO, 32'h0403_0201);
    reg_wr(rfd_pkg::REG_UID_HI, 32'h0807_0605);
    fr[0] = 8'h20;
    for (int i = 2; i < 10; i++)
      fr[i] = i - 1;
    req(10, 1'b1, 1);
    fr[9] = 8'h00;
    req(10, 1'b1, 0);
  endtask
  task automatic t_inv();
    fr[0] = 8'h34;
    fr[1] = 8'h01;
    fr[2] = 8'ha5;
    req(3, 1'b1, 1);
    chk({inventory_o, family_vld_o, family_o, single_slot_o}, 11'h74b);
    fr[0] = 8'h04;
    req(2, 1'b1, 1);
    chk({family_vld_o, single_slot_o}, 2'h0);
    reg_wr(rfd_pkg::REG_STATE, 32'h1);
    fr[0] = 8'h24;
    req(2, 1'b1, 0);
    fr[0] = 8'h00;
    req(2, 1'b1, 1);
    reg_wr(rfd_pkg::REG_STATE, 32'h0);
  endtask
  task automatic t_ext();
    fr[0] = 8'h08;
    fr[1] = rfd_pkg::CMD_SYSINFO;
    req(2, 1'b1, 1);
    chk({ext_o, rich_info_o, option_o}, 3'h6);
    fr[0] = 8'h40;
    req(2, 1'b1, 1);
    chk({ext_o, rich_info_o, option_o}, 3'h1);
    fr[0] = 8'h80;
    req(2, 1'b1, 1);
    reg_rd(rfd_pkg::REG_STATUS);
    chk(rd, 32'h0003_2b80);
    fr[0] = 8'h00;
    fr[1] = 8'h20;
    req(2, 1'b1, 1);
    chk(ext_o, 1'b1);
  endtask
  task automatic t_resp(input logic e);
    int s0;
    s0 = n_sof;
    txq.delete();
    @(posedge sys_clk_i);
    resp_start_i <= 1'b1;
    resp_err_i <= e;
    resp_code_i <= 8'h0f;
    resp_crc_i <= 16'hbeef;
    @(posedge sys_clk_i);
    resp_start_i <= 1'b0;
    repeat (10) @(posedge sys_clk_i);
    chk(n_sof - s0, 1);
    chk(txq.size(), e ? 4 : 3);
    chk(txq[0], {7'h0, e});
    if (e)
      chk(txq[1], 8'h0f);
    chk({txq[e ? 2 : 1], txq[e ? 3 : 2]}, 16'hefbe);
  endtask
  task automatic t_data();
    txq.delete();
    @(posedge sys_clk_i);
    resp_start_i <= 1'b1;
    resp_err_i <= 1'b0;
    resp_pl_i <= 1'b1;
    @(posedge sys_clk_i);
    resp_start_i <= 1'b0;
    pl_valid_i <= 1'b1;
    pl_byte_i <= 8'h5a;
    do @(posedge sys_clk_i); while (pl_ready_o !== 1'b1);
    pl_byte_i <= 8'hc3;
    pl_last_i <= 1'b1;
    do @(posedge sys_clk_i); while (pl_ready_o !== 1'b1);
    pl_valid_i <= 1'b0;
    pl_last_i <= 1'b0;
    repeat (8) @(posedge sys_clk_i);
    chk(txq.size(), 5);
    chk({txq[0], txq[1], txq[2]}, 24'h005ac3);
    chk({txq[3], txq[4]}, 16'hefbe);
  endtask
  initial
  begin
    repeat (20) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    @(posedge sys_clk_i);
    t_regs();
    t_plain();
    t_select();
    t_addr();
    t_inv();
    t_ext();
    t_resp(1'b0);
    t_resp(1'b1);
    t_data();
    stop_test();
  end
endmodule
